/* File: pkg/counter_array_pkg.sv */
// package: register map, field positions and types for the counter array waveform block
package counter_array_pkg;
    localparam int num_channels = 3;
    localparam logic [7:0] addr_control = 8'h00;
    localparam logic [7:0] addr_mode = 8'h04;
    localparam logic [7:0] addr_pwm_control = 8'h08;
    localparam logic [7:0] addr_counter = 8'h0C;
    localparam logic [7:0] addr_wd_update = 8'h10;
    localparam logic [7:0] addr_chan_base = 8'h20;
    localparam logic [7:0] addr_chan_stride = 8'h10;
    localparam logic [3:0] chan_off_mode = 4'h0;
    localparam logic [3:0] chan_off_low = 4'h4;
    localparam logic [3:0] chan_off_high = 4'h8;
    localparam int cm_wide_pwm = 7;
    localparam int cm_cmp_enable = 6;
    localparam int cm_match_flag_en = 3;
    localparam int cm_toggle = 2;
    localparam int cm_pwm = 1;
    localparam int cm_int_enable = 0;
    localparam int pc_reload_sel = 7;
    localparam int pc_overflow_flag = 5;
    localparam int pc_auto_reload = 3;
    localparam int cc_overflow = 7;
    localparam int cc_run = 6;
    localparam int md_wd_enable = 6;
    localparam logic [2:0] cycle_len_8 = 3'h0;
    localparam int base_width = 8;
    localparam int wd_channel = 2;
    localparam logic [7:0] reset_mode = 8'h00;
    localparam logic [7:0] reset_md = 8'h40;
    localparam logic [15:0] counter_max = 16'hFFFF;
    localparam logic [1:0] resp_okay = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;

    typedef enum logic [4:0] {
        mode_off = 5'b00001,
        mode_freq = 5'b00010,
        mode_pwm_n = 5'b00100,
        mode_pwm_16 = 5'b01000,
        mode_compare = 5'b10000
    } chan_mode_t;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axil_rsp_t;
endpackage

/* File: logic/counter_array_waveform.sv */
// counter array with three compare channels: frequency, pwm and watchdog modes
// Notes on behaviour
// - frequency mode: high byte is clocks between toggles; zero counts 256.
// - frequency mode: low byte match toggles output, adds high byte to low.
// - frequency mode needs comparator, toggle and pwm enables all set.
// - frequency mode with match enable flags full 16-bit compare equality.
// - all 8..15 bit pwm channels share one cycle-length field.
// - 8-bit pwm: high on low-byte match, low on low-byte overflow.
// - 8-bit pwm: low byte reloads from high byte at low-byte rollover.
// - 8-bit pwm chosen by comparator and pwm enables with cycle length 000b.
// - 8-bit pwm: match sets channel flag; falling edge sets pwm overflow flag.
// - low-byte write clears comparator enable; high-byte write sets it.
// - comparator enable clear holds pwm output low.
// - reload-select bit steers compare byte accesses to auto-reload register.
// - N-bit pwm: high when low N bits match, low on bit-N overflow.
// - bit-N overflow sets pwm overflow flag and loads reload into compare.
// - cycle-length field selects N, period 2^N counter clocks.
// - 9..15 bit pwm with match enable flags each rising-edge match.
// - 16-bit pwm when comparator, pwm and wide select set.
// - 16-bit pwm: high on 16-bit match, low on 16-bit overflow.
// - 16-bit pwm: match sets channel flag; counter overflow flag marks fall.
// - watchdog enable makes channel 2 the watchdog; low byte holds offset.
// - watchdog enabled by reset; resets device when updates come too late.
// - 16-bit pwm uses auto-reload when pwm control bit 3 is set.
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module counter_array_waveform
(
    input wire logic clock,
    input wire logic rst,
    input wire logic counter_tick,
    input wire counter_array_pkg::axil_req_t bus_req,
    output counter_array_pkg::axil_rsp_t bus_rsp,
    output logic [2:0] channel_output_pin,
    output logic watchdog_reset
);
    import counter_array_pkg::*;

    logic [7:0] array_control_register_r;
    logic [7:0] array_mode_register_r;
    logic [7:0] pwm_control_register_r;
    logic [15:0] counter_r;
    logic [7:0] channel_mode_register_r [num_channels];
    logic [15:0] channel_compare_word_r [num_channels];
    logic [15:0] reload_word_r [num_channels];
    logic [2:0] out_r;
    logic [2:0] match_hit;
    logic [2:0] event_set;
    chan_mode_t mode [num_channels];

    // write channel: address and data may arrive in either order
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic wr_go;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [1:0] bresp_r;
    logic wr_ok;
    logic rd_ok;

    assign bus_rsp.awready = !aw_held_r && !bvalid_r;
    assign bus_rsp.wready = !w_held_r && !bvalid_r;
    assign bus_rsp.bvalid = bvalid_r;
    assign bus_rsp.bresp = bresp_r;
    assign bus_rsp.arready = !rvalid_r;
    assign bus_rsp.rvalid = rvalid_r;
    assign bus_rsp.rdata = rdata_r;
    assign bus_rsp.rresp = rresp_r;
    assign channel_output_pin = out_r;
    assign wr_go = aw_held_r && w_held_r && !bvalid_r;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= resp_okay;
        end
        else
        begin
            if (bus_req.awvalid && bus_rsp.awready)
            begin
                aw_held_r <= 1'b1;
                aw_addr_r <= bus_req.awaddr;
            end
            if (bus_req.wvalid && bus_rsp.wready)
            begin
                w_held_r <= 1'b1;
                w_data_r <= bus_req.wdata;
                w_strb_r <= bus_req.wstrb;
            end
            if (wr_go)
            begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? resp_okay : resp_slverr;
            end
            else if (bvalid_r && bus_req.bready)
            begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // address decode shared by reads and writes
    function automatic logic decode_ok(input logic [7:0] a);
        logic [7:0] rel;
        rel = a - addr_chan_base;
        if (a == addr_control || a == addr_mode || a == addr_pwm_control ||
            a == addr_counter || a == addr_wd_update)
            return 1'b1;
        return (a >= addr_chan_base) && (rel < 8'(num_channels) * addr_chan_stride) &&
            (rel[3:0] == chan_off_mode || rel[3:0] == chan_off_low ||
             rel[3:0] == chan_off_high);
    endfunction

    assign wr_ok = decode_ok(aw_addr_r);
    assign rd_ok = decode_ok(bus_req.araddr);

    logic wr_lane;
    assign wr_lane = wr_go && w_strb_r[0];

    logic wd_on;
    assign wd_on = array_mode_register_r[md_wd_enable];
    logic [2:0] cycle_len;
    assign cycle_len = pwm_control_register_r[2:0];

    // overflow out of bit N; N = 8 + cycle length
    logic [15:0] n_mask;
    logic n_overflow, low_overflow, full_overflow;
    logic run_tick, n_wrap, low_wrap, full_wrap;
    assign n_mask = 16'((32'h0000_0001 << (base_width + 32'(cycle_len))) - 32'h0000_0001);
    assign n_overflow = counter_tick && ((counter_r & n_mask) == n_mask);
    assign low_overflow = counter_tick && (counter_r[7:0] == 8'hFF);
    assign full_overflow = counter_tick && (counter_r == counter_max);
    assign run_tick = counter_tick && (array_control_register_r[cc_run] || wd_on);
    assign low_wrap = run_tick && counter_r[7:0] == 8'h00;
    assign n_wrap = run_tick && (counter_r & n_mask) == 16'h0000;
    assign full_wrap = run_tick && counter_r == 16'h0000;

    always_ff @(posedge clock)
    begin
        if (rst)
            counter_r <= 16'h0000;
        else if (wr_lane && !wd_on && aw_addr_r == addr_counter)
            counter_r <= w_data_r[15:0];
        else if (run_tick)
            counter_r <= counter_r + 16'h0001;
    end

    genvar ch;
    generate
        for (ch = 0; ch < num_channels; ch++)
        begin : g_ch
            logic [7:0] cm;
            logic [7:0] ch_addr;
            logic sel_low;
            logic sel_high;
            logic sel_mode;
            logic wd_here;
            logic [7:0] freq_step;
            assign cm = channel_mode_register_r[ch];
            assign ch_addr = addr_chan_base + 8'(ch) * addr_chan_stride;
            assign sel_low = wr_lane && aw_addr_r == ch_addr + 8'(chan_off_low);
            assign sel_high = wr_lane && aw_addr_r == ch_addr + 8'(chan_off_high);
            assign sel_mode = wr_lane && aw_addr_r == ch_addr + 8'(chan_off_mode);
            assign wd_here = wd_on && (ch == wd_channel);
            // 0x00 wraps naturally in 8-bit add, giving 256 clocks
            assign freq_step = channel_compare_word_r[ch][15:8];

            always_comb
            begin
                if (wd_here)
                    mode[ch] = mode_compare;
                else if (cm[cm_cmp_enable] && cm[cm_pwm] && cm[cm_wide_pwm])
                    mode[ch] = mode_pwm_16;
                else if (cm[cm_cmp_enable] && cm[cm_pwm] && cm[cm_toggle])
                    mode[ch] = mode_freq;
                else if (cm[cm_pwm])
                    mode[ch] = mode_pwm_n;
                else
                    mode[ch] = mode_off;
            end

            always_comb
            begin
                case (mode[ch])
                    mode_freq: match_hit[ch] = run_tick &&
                        counter_r[7:0] == channel_compare_word_r[ch][7:0];
                    mode_pwm_n: match_hit[ch] = run_tick && ((counter_r & n_mask) ==
                        (channel_compare_word_r[ch] & n_mask));
                    default: match_hit[ch] = run_tick &&
                        counter_r == channel_compare_word_r[ch];
                endcase
            end

            // channel flag: 16-bit equality in frequency mode, match in both pwm modes
            always_comb
            begin
                event_set[ch] = 1'b0;
                if (cm[cm_match_flag_en] && cm[cm_cmp_enable] && !wd_here)
                begin
                    case (mode[ch])
                        mode_freq: event_set[ch] = run_tick &&
                            counter_r == channel_compare_word_r[ch];
                        mode_pwm_n: event_set[ch] = match_hit[ch];
                        mode_pwm_16: event_set[ch] = match_hit[ch];
                        mode_compare: event_set[ch] = match_hit[ch];
                        default: event_set[ch] = 1'b0;
                    endcase
                end
            end

            always_ff @(posedge clock)
            begin
                if (rst)
                    channel_mode_register_r[ch] <= reset_mode;
                else if (sel_mode && !wd_here)
                    channel_mode_register_r[ch] <= w_data_r[7:0];
                else if (sel_low && !pwm_control_register_r[pc_reload_sel])
                    channel_mode_register_r[ch][cm_cmp_enable] <= 1'b0;
                else if (sel_high && !pwm_control_register_r[pc_reload_sel])
                    channel_mode_register_r[ch][cm_cmp_enable] <= 1'b1;
            end

            always_ff @(posedge clock)
            begin
                if (rst)
                    reload_word_r[ch] <= 16'h0000;
                else if (pwm_control_register_r[pc_reload_sel] && !wd_here)
                begin
                    if (sel_low)
                        reload_word_r[ch][7:0] <= w_data_r[7:0];
                    if (sel_high)
                        reload_word_r[ch][15:8] <= w_data_r[7:0];
                end
            end

            always_ff @(posedge clock)
            begin
                if (rst)
                    channel_compare_word_r[ch] <= 16'h0000;
                else if (wd_here && sel_high)
                    // watchdog update: counter high byte plus offset
                    channel_compare_word_r[ch][15:8] <=
                        counter_r[15:8] + channel_compare_word_r[ch][7:0];
                else if (!pwm_control_register_r[pc_reload_sel] && (sel_low || sel_high))
                begin
                    if (sel_low && !wd_here)
                        channel_compare_word_r[ch][7:0] <= w_data_r[7:0];
                    if (sel_high && !wd_here)
                        channel_compare_word_r[ch][15:8] <= w_data_r[7:0];
                end
                else if (mode[ch] == mode_freq && match_hit[ch])
                    channel_compare_word_r[ch][7:0] <=
                        channel_compare_word_r[ch][7:0] + freq_step;
                else if (mode[ch] == mode_pwm_n && cycle_len == cycle_len_8 && low_overflow)
                    channel_compare_word_r[ch][7:0] <=
                        channel_compare_word_r[ch][15:8];
                else if (mode[ch] == mode_pwm_n && cycle_len != cycle_len_8 && n_overflow)
                    channel_compare_word_r[ch] <= reload_word_r[ch];
                else if (mode[ch] == mode_pwm_16 && full_overflow &&
                         pwm_control_register_r[pc_auto_reload])
                    channel_compare_word_r[ch] <= reload_word_r[ch];
            end

            // clear one clock after overflow, so high time is period minus compare
            always_ff @(posedge clock)
            begin
                if (rst)
                    out_r[ch] <= 1'b0;
                else
                begin
                    case (mode[ch])
                        mode_freq:
                            if (match_hit[ch])
                                out_r[ch] <= !out_r[ch];
                        mode_pwm_n:
                            if (!cm[cm_cmp_enable])
                                out_r[ch] <= 1'b0;
                            else if (match_hit[ch])
                                out_r[ch] <= 1'b1;
                            else if (cycle_len == cycle_len_8 ? low_wrap : n_wrap)
                                out_r[ch] <= 1'b0;
                        mode_pwm_16:
                            if (!cm[cm_cmp_enable])
                                out_r[ch] <= 1'b0;
                            else if (match_hit[ch])
                                out_r[ch] <= 1'b1;
                            else if (full_wrap)
                                out_r[ch] <= 1'b0;
                        default:
                            out_r[ch] <= out_r[ch];
                    endcase
                end
            end
        end
    endgenerate

    // pwm control: reload select, overflow flag, auto-reload, cycle length
    logic pwm_any_n;
    always_comb
    begin
        pwm_any_n = 1'b0;
        for (int i = 0; i < num_channels; i++)
            if (mode[i] == mode_pwm_n)
                pwm_any_n = 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            pwm_control_register_r <= 8'h00;
        else
        begin
            if (wr_lane && aw_addr_r == addr_pwm_control)
                pwm_control_register_r <= w_data_r[7:0];
            // hardware set beats a software clear in the same cycle
            if (pwm_any_n && (cycle_len == cycle_len_8 ? low_overflow : n_overflow))
                pwm_control_register_r[pc_overflow_flag] <= 1'b1;
        end
    end

    // control: counter overflow, run, per-channel event flags
    always_ff @(posedge clock)
    begin
        if (rst)
            array_control_register_r <= 8'h00;
        else
        begin
            if (wr_lane && aw_addr_r == addr_control)
            begin
                array_control_register_r[cc_overflow] <= w_data_r[cc_overflow];
                array_control_register_r[cc_run] <= w_data_r[cc_run];
                array_control_register_r[2:0] <= w_data_r[2:0];
            end
            if (run_tick && full_overflow)
                array_control_register_r[cc_overflow] <= 1'b1;
            for (int i = 0; i < num_channels; i++)
                if (event_set[i])
                    array_control_register_r[i] <= 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            array_mode_register_r <= reset_md;
        else if (wr_lane && aw_addr_r == addr_mode)
            array_mode_register_r <= w_data_r[7:0];
    end

    // watchdog: low-byte overflow while high bytes match, or forced flag write
    always_ff @(posedge clock)
    begin
        if (rst)
            watchdog_reset <= 1'b0;
        else
            watchdog_reset <= wd_on && ((low_overflow &&
                counter_r[15:8] == channel_compare_word_r[wd_channel][15:8]) ||
                (wr_lane && aw_addr_r == addr_control && w_data_r[wd_channel]));
    end

    // read channel
    logic [31:0] rd_val;
    always_comb
    begin
        logic [7:0] rel;
        int idx;
        rel = bus_req.araddr - addr_chan_base;
        idx = int'(rel[7:4]);
        rd_val = 32'h0000_0000;
        case (bus_req.araddr)
            addr_control: rd_val = {24'h00_0000, array_control_register_r & 8'hC7};
            addr_mode: rd_val = {24'h00_0000, array_mode_register_r};
            addr_pwm_control: rd_val = {24'h00_0000, pwm_control_register_r};
            addr_counter: rd_val = {16'h0000, counter_r};
            addr_wd_update: rd_val = 32'h0000_0000;
            default:
                if (rd_ok && idx < num_channels)
                begin
                    if (rel[3:0] == chan_off_mode)
                        rd_val = {24'h00_0000, channel_mode_register_r[idx]};
                    else if (rel[3:0] == chan_off_low)
                        rd_val = {24'h00_0000, pwm_control_register_r[pc_reload_sel] ?
                            reload_word_r[idx][7:0] : channel_compare_word_r[idx][7:0]};
                    else
                        rd_val = {24'h00_0000, pwm_control_register_r[pc_reload_sel] ?
                            reload_word_r[idx][15:8] : channel_compare_word_r[idx][15:8]};
                end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= resp_okay;
        end
        else if (bus_req.arvalid && !rvalid_r)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_val;
            rresp_r <= rd_ok ? resp_okay : resp_slverr;
        end
        else if (rvalid_r && bus_req.rready)
            rvalid_r <= 1'b0;
    end
endmodule

/* File: sim/counter_array_waveform_sva.sv */
// checker: bus handshake, reset state and watchdog pulse
`timescale 1ns/1ps
module counter_array_waveform_sva
(
    input wire logic clock,
    input wire logic rst,
    input wire logic counter_tick,
    input wire counter_array_pkg::axil_req_t bus_req,
    input wire counter_array_pkg::axil_rsp_t bus_rsp,
    input wire logic [2:0] channel_output_pin,
    input wire logic watchdog_reset
);
    import counter_array_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // reset is the cause here, so not disabled by it
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> channel_output_pin == 3'b000
        && !watchdog_reset && !bus_rsp.bvalid && !bus_rsp.rvalid)
        else $error("not quiet after reset");
    a_write_answer: assert property (bus_req.awvalid && bus_rsp.awready && bus_req.wvalid
        && bus_rsp.wready |-> ##[1:3] bus_rsp.bvalid)
        else $error("write response late");
    a_read_answer: assert property (bus_req.arvalid && bus_rsp.arready |=> bus_rsp.rvalid)
        else $error("read data late");
    a_bresp_holds: assert property (bus_rsp.bvalid && !bus_req.bready
        |=> bus_rsp.bvalid && $stable(bus_rsp.bresp))
        else $error("bvalid dropped");
    a_rdata_holds: assert property (bus_rsp.rvalid && !bus_req.rready
        |=> bus_rsp.rvalid && $stable(bus_rsp.rdata) && $stable(bus_rsp.rresp))
        else $error("rvalid dropped");
    a_bvalid_drops: assert property (bus_rsp.bvalid && bus_req.bready |=> !bus_rsp.bvalid)
        else $error("bvalid repeated");
    a_read_refused: assert property (bus_rsp.rvalid |-> !bus_rsp.arready)
        else $error("ar taken while rvalid");
    a_write_refused: assert property (bus_rsp.bvalid |-> !bus_rsp.awready && !bus_rsp.wready)
        else $error("write taken while bvalid");
    a_wd_pulse_one: assert property (watchdog_reset |=> !watchdog_reset)
        else $error("watchdog pulse too long");
endmodule

bind counter_array_waveform counter_array_waveform_sva i_sva (.clock(clock), .rst(rst),
    .counter_tick(counter_tick), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .channel_output_pin(channel_output_pin), .watchdog_reset(watchdog_reset));

/* File: sim/waveform_load.sv */
// partner: pin load measuring high time and period
`timescale 1ns/1ps
module waveform_load
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [2:0] pin,
    output logic [16:0] hi_len [3],
    output logic [16:0] period [3],
    output int falls [3]
);
    logic [2:0] last_r;
    logic [16:0] hi_cnt [3];
    logic [16:0] per_cnt [3];
    // counts are samples of a registered pin
    always_ff @(posedge clock)
    begin
        last_r <= pin;
        if (rst)
            falls <= '{0, 0, 0};
        else
            for (int i = 0; i < 3; i++)
            begin
                per_cnt[i] <= per_cnt[i] + 17'h1;
                if (pin[i])
                    hi_cnt[i] <= hi_cnt[i] + 17'h1;
                if (pin[i] && !last_r[i])
                begin
                    hi_cnt[i] <= 17'h1;
                    per_cnt[i] <= 17'h1;
                    period[i] <= per_cnt[i];
                end
                if (!pin[i] && last_r[i])
                begin
                    hi_len[i] <= hi_cnt[i];
                    falls[i] <= falls[i] + 1;
                end
            end
    end
endmodule

/* File: sim/counter_array_waveform_bench.sv */
// bench: register, waveform and watchdog tests
`timescale 1ns/1ps
module counter_array_waveform_bench;
    import counter_array_pkg::*;
    typedef struct {
        logic [7:0] mode;
        logic [7:0] pctl;
        logic [7:0] low;
        logic [7:0] high;
        logic [15:0] cnt;
        int need;
        logic [16:0] hi;
        logic [16:0] per;
        logic [7:0] cmask;
        logic [7:0] pmask;
    } row_t;
    logic clock;
    logic rst;
    logic counter_tick;
    axil_req_t bus_req;
    axil_rsp_t bus_rsp;
    logic [2:0] pins;
    logic watchdog_reset;
    logic [16:0] hi_len [3];
    logic [16:0] period [3];
    int falls [3];
    int miscompares = 0;
    int check_count = 0;
    int wd_pulses = 0;
    int base;
    logic [31:0] d;
    logic [1:0] r;
    // per 0: a 16-bit period is too long to wait for
    row_t rows [5] = '{
        '{8'hCA, 8'h00, 8'h00, 8'hFF, 16'hFE00, 1, 17'd256, 17'd0, 8'h81, 8'h00},
        '{8'h4A, 8'h00, 8'h40, 8'h40, 16'h0, 3, 17'd192, 17'd256, 8'h01, 8'h20},
        '{8'h46, 8'h00, 8'h00, 8'h10, 16'h0, 3, 17'd16, 17'd32, 8'h00, 8'h00},
        '{8'h46, 8'h00, 8'h00, 8'h00, 16'h0, 3, 17'd256, 17'd512, 8'h00, 8'h00},
        '{8'h4A, 8'h81, 8'h00, 8'h01, 16'h0, 3, 17'd256, 17'd512, 8'h01, 8'h20}
    };

    counter_array_waveform i_dut (.clock(clock), .rst(rst), .counter_tick(counter_tick),
        .bus_req(bus_req), .bus_rsp(bus_rsp), .channel_output_pin(pins),
        .watchdog_reset(watchdog_reset));
    waveform_load i_load (.clock(clock), .rst(rst), .pin(pins), .hi_len(hi_len),
        .period(period), .falls(falls));

    always @(posedge clock)
        if (watchdog_reset === 1'b1)
            wd_pulses <= wd_pulses + 1;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] s);
        int n = 0;
        @(posedge clock);
        bus_req.awaddr <= a;
        bus_req.awvalid <= 1'b1;
        bus_req.wdata <= v;
        bus_req.wstrb <= 4'h1;
        bus_req.wvalid <= 1'b1;
        // late bready makes the response wait
        do
        begin
            @(posedge clock);
            n++;
            if (bus_rsp.awready) bus_req.awvalid <= 1'b0;
            if (bus_rsp.wready) bus_req.wvalid <= 1'b0;
            if (bus_rsp.bvalid && !bus_req.bready) bus_req.bready <= 1'b1;
        end while (!(bus_rsp.bvalid && bus_req.bready) && n < 100);
        s = bus_rsp.bresp;
        bus_req.bready <= 1'b0;
        check(32'(n < 100), 32'h1);
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
        int n = 0;
        @(posedge clock);
        bus_req.araddr <= a;
        bus_req.arvalid <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
            if (bus_rsp.arready) bus_req.arvalid <= 1'b0;
            if (bus_rsp.rvalid && !bus_req.rready) bus_req.rready <= 1'b1;
        end while (!(bus_rsp.rvalid && bus_req.rready) && n < 100);
        v = bus_rsp.rdata;
        s = bus_rsp.rresp;
        bus_req.rready <= 1'b0;
        check(32'(n < 100), 32'h1);
    endtask

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        miscompares++;
        final_report();
    end

    initial
    begin
        rst = 1'b1;
        counter_tick = 1'b1;
        bus_req = '0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        bus_read(8'h04, d, r);
        check(d, 32'h40);
        bus_read(8'h20, d, r);
        check(d, 32'h0);
        bus_read(8'hFC, d, r);
        check(32'(r), 32'(resp_slverr));
        bus_write(8'hF0, 32'h0, r);
        check(32'(r), 32'(resp_slverr));
        bus_write(8'h04, 32'h0, r);
        $display("reset and map test done");
        for (int i = 0; i < 5; i++)
        begin
            bus_write(8'h20, 32'h2, r);
            bus_write(8'h08, 32'(rows[i].pctl), r);
            bus_write(8'h24, 32'(rows[i].low), r);
            bus_write(8'h28, 32'(rows[i].high), r);
            bus_write(8'h20, 32'(rows[i].mode), r);
            bus_write(8'h00, 32'h40, r);
            if (rows[i].cnt != 16'h0)
                bus_write(8'h0C, 32'(rows[i].cnt), r);
            base = falls[0];
            while (falls[0] < base + rows[i].need) @(posedge clock);
            check(32'(hi_len[0]), 32'(rows[i].hi));
            if (rows[i].per != 17'h0)
                check(32'(period[0]), 32'(rows[i].per));
            bus_read(8'h00, d, r);
            check(32'(d[7:0] & rows[i].cmask), 32'(rows[i].cmask));
            bus_read(8'h08, d, r);
            check(32'(d[7:0] & rows[i].pmask), 32'(rows[i].pmask));
            $display("waveform row %0d done", i);
        end
        bus_write(8'h08, 32'h0, r);
        bus_write(8'h24, 32'h40, r);
        bus_read(8'h20, d, r);
        check(32'(d[6]), 32'h0);
        base = 0;
        repeat (600)
        begin
            @(posedge clock);
            base += int'(pins[0] !== 1'b0);
        end
        check(base, 0);
        bus_write(8'h28, 32'h40, r);
        bus_read(8'h20, d, r);
        check(32'(d[6]), 32'h1);
        $display("comparator enable test done");
        bus_write(8'h44, 32'h1, r);
        bus_write(8'h04, 32'h40, r);
        bus_write(8'h48, 32'h0, r);
        base = wd_pulses;
        repeat (250) @(posedge clock);
        check(wd_pulses, base);
        repeat (300) @(posedge clock);
        check(wd_pulses, base + 1);
        base = wd_pulses;
        bus_write(8'h00, 32'h44, r);
        repeat (4) @(posedge clock);
        check(wd_pulses, base + 1);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        bus_read(8'h04, d, r);
        check(d, 32'h40);
        $display("watchdog test done");
        final_report();
    end
endmodule
